// ---- byte_invert.sv ----
// Per-byte inversion coder used for both directions.
// Pure combinational; callers register the result, except the controller's write encoder, which drives the pins directly.
`timescale 1ns/1ps
`default_nettype none
module byte_invert
  import rsbi_pkg::*;
(
  input wire logic [7:0] data_i,
  input wire logic encode_i,
  input wire logic flag_n_i,
  output logic [7:0] data_o,
  output logic flag_n_o
);
  always_comb begin
    if (encode_i) begin
      flag_n_o = !(zeros(data_i) > 4'(ZERO_LIMIT));
      data_o = flag_n_o ? data_i : ~data_i;
    end else begin
      flag_n_o = flag_n_i;
      data_o = flag_n_i ? data_i : ~data_i;
    end
  end
endmodule : byte_invert
`default_nettype wire

// ---- read_strobe_and_bus_inversion_bench.sv ----
// Bench joining both ends through the pin bundle.
// Drives the controller over classic Wishbone; feeds device read data.
`timescale 1ns/1ps
`default_nettype none
module read_strobe_and_bus_inversion_bench
  import rsbi_pkg::*;
;
  logic clk_i;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] rd_data = 16'h0;
  logic [15:0] wr_data;
  logic [15:0] wr_seen;
  logic wr_valid;
  logic strobe_mode;
  int wr_cnt = 0;
  int error_cnt = 0;
  int n_tests = 0;
  logic [11:0] mr1_tab [4] = '{12'h200, 12'h000, 12'h300, 12'h100};
  logic [15:0] pat [4] = '{16'h0000, 16'hFFFF, 16'h0F07, 16'h7F80};

  rsbi_if link();
  rsbi_device i_rsbi_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .rd_data_i(rd_data), .wr_data_o(wr_data), .wr_valid_o(wr_valid),
    .strobe_mode_o(strobe_mode));
  rsbi_controller i_rsbi_controller (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .link(link));
  rsbi_properties i_rsbi_properties (.clk_i(clk_i), .rst_i(rst_i),
    .link_clk(link.link_clk), .mrs_valid(link.mrs_valid),
    .mrs_sel(link.mrs_sel), .mrs_data(link.mrs_data),
    .rd_cmd(link.rd_cmd), .read_training_cmd_cmd(link.read_training_cmd_cmd), .dq_dev(link.dq_dev),
    .dq_dev_oe(link.dq_dev_oe), .flag_dev(link.flag_dev),
    .flag_dev_oe(link.flag_dev_oe), .flag_odt(link.flag_odt),
    .edc_o(link.edc_o), .dq_ctl(link.dq_ctl), .dq_ctl_oe(link.dq_ctl_oe),
    .flag_ctl_oe(link.flag_ctl_oe));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Write pulse is one cycle wide, so catch it here
  always @(posedge clk_i) begin
    if (wr_valid === 1'b1) begin
      wr_seen <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (ack !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    rdat = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic cmd(input logic [31:0] c);
    int n;
    wb(1'b1, ADDR_CMD, c);
    n = 0;
    do begin
      wb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 4000);
    if (rdat[0] !== 1'b0) begin
      error_cnt++;
      close_out();
    end
  endtask : cmd

  task automatic mrs(input logic [2:0] s, input logic [11:0] d);
    cmd({16'h0001, 1'b0, s, d});
    repeat (MODE_SET_CYCLES + 12) @(posedge clk_i);
  endtask : mrs

  task automatic wr_xfer(input logic [15:0] v);
    int c;
    int n;
    c = wr_cnt;
    wb(1'b1, ADDR_WDATA, {16'h0, v});
    cmd(32'h0004_0000);
    n = 0;
    while (wr_cnt == c && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(wr_cnt - c), 32'h1);
    chk({16'h0, wr_seen}, {16'h0, v});
  endtask : wr_xfer

  task automatic rd_xfer(input logic [15:0] v);
    rd_data <= v;
    cmd(32'h0002_0000);
    wb(1'b0, ADDR_RDATA, 32'h0);
    chk({16'h0, rdat[15:0]}, {16'h0, v});
  endtask : rd_xfer

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, strobe_mode}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      mrs(SEL_MR1, mr1_tab[m]);
      for (int k = 0; k < 4; k++) begin
        wr_xfer(pat[k]);
        rd_xfer(pat[k]);
      end
    end
    mrs(SEL_MR1, 12'h200);
    mrs(SEL_MR4, 12'h00A);
    chk({28'h0, link.edc_o}, 32'hA);
    mrs(SEL_MR4, 12'h80A);
    // Strobe mode is turned on here, after odd-pin inversion is set in reg four
    mrs(SEL_MR2, 12'h200);
    chk({31'h0, strobe_mode}, 32'h1);
    chk({28'h0, link.edc_o}, 32'hF);
    mrs(SEL_MODE_REGISTER_TWELVE, 12'h004);
    chk({28'h0, link.edc_o}, 32'hF);
    wr_xfer(16'h0F07);
    rd_xfer(16'h7F80);
    cmd(32'h0020_0000);
    chk({28'h0, link.edc_o}, 32'hF);
    mrs(SEL_MODE_REGISTER_TWELVE, 12'h000);
    mrs(SEL_MR2, 12'h000);
    chk({31'h0, strobe_mode}, 32'h0);
    chk({28'h0, link.edc_o & 4'h5}, 32'h0);
    close_out();
  end
endmodule : read_strobe_and_bus_inversion_bench
`default_nettype wire

// ---- rsbi_controller.sv ----
// Controller end: Wishbone registers, link clock divider, coding.
// Assumes a classic Wishbone master on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rsbi_controller
  import rsbi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  rsbi_if.controller link
);
  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} cphase_e;
  typedef struct packed {
    cphase_e phase;
    logic [3:0] divcnt;
    logic lclk;
    logic [31:0] cmd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [1:0] dev_s1;
    logic [1:0] dev_s2;
    logic busy;
    logic write_inversion_enable;
    logic second;
    logic ack;
    logic [31:0] dat;
  } cstate_s;
  cstate_s c_reg, c_next;
  logic [15:0] enc_w, dec_r;
  logic [1:0] enc_f, unused_f;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_byte
      // Controller encodes writes, decodes reads
      byte_invert u_enc (
        .data_i(c_reg.wdata[g*BYTE_W +: BYTE_W]),
        .encode_i(1'b1),
        .flag_n_i(1'b1),
        .data_o(enc_w[g*BYTE_W +: BYTE_W]),
        .flag_n_o(enc_f[g])
      );
      byte_invert u_dec (
        .data_i(link.dq_dev[g*BYTE_W +: BYTE_W]),
        .encode_i(1'b0),
        .flag_n_i(link.flag_dev[g]),
        .data_o(dec_r[g*BYTE_W +: BYTE_W]),
        .flag_n_o(unused_f[g])
      );
    end
  endgenerate

  always_comb begin
    logic req;
    c_next = c_reg;
    c_next.ack = 1'b0;
    req = cyc_i && stb_i && !c_reg.ack;
    if (req) begin
      c_next.ack = 1'b1;
      c_next.dat = 32'h0000_0000;
      case (adr_i)
        ADDR_CMD: if (we_i && !c_reg.busy) begin
          c_next.cmd = dat_i;
          c_next.busy = 1'b1;
          c_next.phase = C_LOW;
          c_next.divcnt = 4'h0;
          c_next.second = 1'b0;
          // Track write inversion so writes are coded only when on
          if (dat_i[16] && dat_i[14:12] == SEL_MR1) begin
            c_next.write_inversion_enable = dat_i[MR1_READ_INVERSION_ENABLE_N_BIT + 1];
          end
        end
        ADDR_WDATA: if (we_i) c_next.wdata = dat_i[15:0];
        ADDR_RDATA: c_next.dat = {16'h0000, c_reg.rdata};
        ADDR_STATUS: c_next.dat = {31'h0, c_reg.busy};
        default: ;
      endcase
    end
    // Link clock: 16 core cycles per half period
    case (c_reg.phase)
      C_IDLE: c_next.lclk = 1'b0;
      C_LOW, C_HIGH: begin
        c_next.divcnt = c_reg.divcnt + 4'h1;
        if (c_reg.divcnt == 4'hF) begin
          c_next.lclk = ~c_reg.lclk;
          if (c_reg.phase == C_HIGH && c_reg.lclk) begin
            // Reads need a second link cycle: preamble, then data
            if ((c_reg.cmd[17] || c_reg.cmd[19]) && !c_reg.second) begin
              c_next.second = 1'b1;
              c_next.phase = C_LOW;
            end else begin
              c_next.phase = C_IDLE;
              c_next.busy = 1'b0;
              c_next.second = 1'b0;
              c_next.rdata = dec_r;
            end
          end else begin
            c_next.phase = C_HIGH;
          end
        end
      end
      default: c_next.phase = C_IDLE;
    endcase
    if (rst_i) begin
      c_next = '0;
      c_next.phase = C_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    c_reg <= c_next;
  end

  // Command word: [11:0] data, [14:12] select, [20:16] strobes
  assign link.link_clk = c_reg.lclk;
  assign link.mrs_data = c_reg.cmd[11:0];
  assign link.mrs_sel = c_reg.cmd[14:12];
  assign link.mrs_valid = c_reg.busy & c_reg.cmd[16];
  assign link.rd_cmd = c_reg.busy & c_reg.cmd[17];
  assign link.wr_cmd = c_reg.busy & c_reg.cmd[18];
  assign link.read_training_cmd_cmd = c_reg.busy & c_reg.cmd[19];
  assign link.write_training_cmd_cmd = c_reg.busy & c_reg.cmd[20];
  assign link.pwr_down = c_reg.cmd[21];
  assign link.dq_ctl = c_reg.write_inversion_enable ? enc_w : c_reg.wdata;
  assign link.dq_ctl_oe = c_reg.busy & c_reg.cmd[18];
  assign link.flag_ctl = c_reg.write_inversion_enable ? enc_f : 2'h3;
  assign link.flag_ctl_oe = c_reg.busy & c_reg.cmd[18] & c_reg.write_inversion_enable;
  assign dat_o = c_reg.dat;
  assign ack_o = c_reg.ack;
endmodule : rsbi_controller
`default_nettype wire

// ---- rsbi_device.sv ----
// Memory-side end: mode registers, read strobe on check pins, inversion.
// Assumes controller drives commands on link clock rising edges.
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rsbi_device
  import rsbi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  rsbi_if.device link,
  input wire logic [15:0] rd_data_i,
  output logic [15:0] wr_data_o,
  output logic wr_valid_o,
  output logic strobe_mode_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_BURST} phase_e;
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [20:0] cmd_s1;
    logic [20:0] cmd_s2;
    logic [11:0] mr1;
    logic [11:0] mr2;
    logic [11:0] mr4;
    logic [11:0] mode_register_twelve;
    logic strobe_mode;
    logic [3:0] delay_cnt;
    logic pins_high;
    phase_e phase;
    logic strobe;
    logic [3:0] edc;
    logic [3:0] edc_oe;
    logic [15:0] dq;
    logic dq_oe;
    logic [1:0] flag;
    logic [1:0] flag_oe;
    logic [1:0] odt;
    logic [15:0] wr_data;
    logic wr_valid;
    logic [1:0] train_fifo;
  } state_s;
  state_s state_reg, state_next;

  logic [20:0] cmd_raw;
  logic read_inversion_enable_on;
  logic write_inversion_enable_on;
  logic [15:0] enc_data, dec_data;
  logic [1:0] enc_flag;
  logic [1:0] unused_flag;
  logic [15:0] dq_ctl_q;
  logic [1:0] flag_ctl_q;
  logic [15:0] dq_ctl_s;
  logic [1:0] flag_ctl_s;

  // Whole command bundle, data included, crosses two flops
  assign cmd_raw = {link.mrs_valid, link.mrs_sel, link.rd_cmd,
    link.wr_cmd, link.read_training_cmd_cmd, link.write_training_cmd_cmd, link.pwr_down,
    link.mrs_data};

  // Data pins stand a whole link cycle, so two flops suffice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_ctl_q <= 16'h0000;
      flag_ctl_q <= 2'h3;
      dq_ctl_s <= 16'h0000;
      flag_ctl_s <= 2'h3;
    end else begin
      dq_ctl_q <= link.dq_ctl;
      flag_ctl_q <= link.flag_ctl;
      dq_ctl_s <= dq_ctl_q;
      flag_ctl_s <= flag_ctl_q;
    end
  end

  assign read_inversion_enable_on = !state_reg.mr1[MR1_READ_INVERSION_ENABLE_N_BIT];
  assign write_inversion_enable_on = state_reg.mr1[MR1_READ_INVERSION_ENABLE_N_BIT + 1];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_byte
      // One encoder and one decoder per byte, each with its own flag
      byte_invert u_enc (
        .data_i(rd_data_i[g*BYTE_W +: BYTE_W]),
        .encode_i(1'b1),
        .flag_n_i(1'b1),
        .data_o(enc_data[g*BYTE_W +: BYTE_W]),
        .flag_n_o(enc_flag[g])
      );
      byte_invert u_dec (
        .data_i(dq_ctl_s[g*BYTE_W +: BYTE_W]),
        .encode_i(1'b0),
        .flag_n_i(write_inversion_enable_on ? flag_ctl_s[g] : 1'b1),
        .data_o(dec_data[g*BYTE_W +: BYTE_W]),
        .flag_n_o(unused_flag[g])
      );
    end
  endgenerate

  always_comb begin
    logic mrs, rd, wr, read_training_cmd, write_training_cmd, pd, edge_up, edge_dn;
    logic [3:0] hold;
    mrs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    read_training_cmd = 1'b0;
    write_training_cmd = 1'b0;
    pd = 1'b0;
    edge_up = 1'b0;
    edge_dn = 1'b0;
    hold = 4'h0;
    state_next = state_reg;
    state_next.clk_sync = {state_reg.clk_sync[1:0], link.link_clk};
    state_next.cmd_s1 = cmd_raw;
    state_next.cmd_s2 = state_reg.cmd_s1;
    // Only the second and third flops are read, never the first
    edge_up = state_reg.clk_sync[2:1] == 2'b01;
    edge_dn = state_reg.clk_sync[2:1] == 2'b10;
    mrs = edge_up & state_reg.cmd_s2[20];
    rd = edge_up & state_reg.cmd_s2[16];
    wr = edge_up & state_reg.cmd_s2[15];
    read_training_cmd = edge_up & state_reg.cmd_s2[14];
    write_training_cmd = edge_up & state_reg.cmd_s2[13];
    pd = state_reg.cmd_s2[12];
    state_next.wr_valid = 1'b0;
    if (mrs) begin
      case (state_reg.cmd_s2[19:17])
        SEL_MR1: state_next.mr1 = state_reg.cmd_s2[11:0];
        SEL_MR2: state_next.mr2 = state_reg.cmd_s2[11:0];
        SEL_MR4: state_next.mr4 = state_reg.cmd_s2[11:0];
        SEL_MODE_REGISTER_TWELVE: state_next.mode_register_twelve = state_reg.cmd_s2[11:0];
        default: ;
      endcase
    end
    // Mode change restarts the settle count
    if (state_next.mr2[MR2_STROBE_BIT] != state_reg.strobe_mode) begin
      state_next.strobe_mode = state_next.mr2[MR2_STROBE_BIT];
      state_next.delay_cnt = MODE_SET_CNT;
      state_next.pins_high = 1'b1;
    end else if (state_reg.delay_cnt != 4'h0) begin
      state_next.delay_cnt = state_reg.delay_cnt - 4'h1;
    end else begin
      state_next.pins_high = 1'b0;
    end
    // Writes decoded the same in either mode
    if (wr) begin
      state_next.wr_data = dec_data;
      state_next.wr_valid = 1'b1;
    end
    if (write_training_cmd && read_inversion_enable_on && write_inversion_enable_on) begin
      state_next.train_fifo = flag_ctl_s;
    end
    // Read framing: one preamble cycle then data
    case (state_reg.phase)
      ST_IDLE: if (rd || read_training_cmd) state_next.phase = ST_PRE;
      ST_PRE: if (edge_up) state_next.phase = ST_BURST;
      // Burst stands half a link cycle so the far end can take it
      ST_BURST: if (edge_dn) state_next.phase = ST_IDLE;
      default: state_next.phase = ST_IDLE;
    endcase
    state_next.strobe = state_reg.phase == ST_IDLE ? 1'b0 :
      state_reg.clk_sync[1];
    state_next.dq_oe = state_reg.phase == ST_BURST;
    if (edge_up && state_reg.phase != ST_IDLE) begin
      state_next.dq = read_inversion_enable_on ? enc_data : rd_data_i;
      state_next.flag = read_inversion_enable_on ? enc_flag : 2'h3;
      if (read_training_cmd && read_inversion_enable_on && write_inversion_enable_on) begin
        state_next.flag = state_reg.train_fifo;
      end
    end
    // Flag drive versus termination
    if (read_inversion_enable_on && state_reg.phase == ST_BURST) begin
      state_next.flag_oe = 2'h3;
      state_next.odt = 2'h0;
    end else begin
      state_next.flag_oe = 2'h0;
      state_next.odt = 2'h3;
    end
    // Check pins: strobe mode ignores the reg four hold pattern and PRBS, but uses its odd-pin inversion bit
    hold = state_reg.mr4[MR4_HOLD_LSB +: EDC_W];
    state_next.edc_oe = 4'hF;
    if (state_reg.pins_high || pd) begin
      state_next.edc = EDC_IDLE;
    end else if (state_reg.strobe_mode) begin
      if (state_reg.phase == ST_IDLE) begin
        state_next.edc = EDC_IDLE;
      end else begin
        state_next.edc = {4{state_next.strobe}};
        if (state_reg.mr4[MR4_ODD_INV_BIT]) begin
          state_next.edc[1] = ~state_next.strobe;
          state_next.edc[3] = ~state_next.strobe;
        end
      end
    end else begin
      // Checksum engine lives elsewhere; hold pattern stands in
      state_next.edc = hold;
    end
    if (rst_i) begin
      state_next = '0;
      state_next.mr1 = 12'h000;
      state_next.mr4[MR4_HOLD_LSB +: EDC_W] = HOLD_RESET;
      state_next.flag = 2'h3;
      state_next.phase = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end

  assign link.dq_dev = state_reg.dq;
  assign link.dq_dev_oe = state_reg.dq_oe;
  assign link.flag_dev = state_reg.flag;
  assign link.flag_dev_oe = state_reg.flag_oe;
  assign link.flag_odt = state_reg.odt;
  assign link.edc_o = state_reg.edc;
  assign link.edc_oe = state_reg.edc_oe;
  assign wr_data_o = state_reg.wr_data;
  assign wr_valid_o = state_reg.wr_valid;
  assign strobe_mode_o = state_reg.strobe_mode;
endmodule : rsbi_device
`default_nettype wire

// ---- rsbi_if.sv ----
// Pin bundle between memory device and controller.
// Two-way pins carry each end's output and enable; each end reads the other's output directly.
`timescale 1ns/1ps
`default_nettype none
interface rsbi_if;
  logic link_clk;
  logic mrs_valid;
  logic [2:0] mrs_sel;
  logic [11:0] mrs_data;
  logic rd_cmd;
  logic wr_cmd;
  logic read_training_cmd_cmd;
  logic write_training_cmd_cmd;
  logic pwr_down;
  logic [15:0] dq_dev;
  logic dq_dev_oe;
  logic [15:0] dq_ctl;
  logic dq_ctl_oe;
  logic [1:0] flag_dev;
  logic [1:0] flag_dev_oe;
  logic [1:0] flag_ctl;
  logic flag_ctl_oe;
  logic [1:0] flag_odt;
  logic [3:0] edc_o;
  logic [3:0] edc_oe;
  modport device (input link_clk, mrs_valid, mrs_sel, mrs_data, rd_cmd,
    wr_cmd, read_training_cmd_cmd, write_training_cmd_cmd, pwr_down, dq_ctl, flag_ctl,
    output dq_dev, dq_dev_oe, flag_dev, flag_dev_oe, flag_odt, edc_o,
    edc_oe);
  modport controller (output link_clk, mrs_valid, mrs_sel, mrs_data,
    rd_cmd, wr_cmd, read_training_cmd_cmd, write_training_cmd_cmd, pwr_down, dq_ctl, dq_ctl_oe,
    flag_ctl, flag_ctl_oe, input dq_dev, flag_dev, edc_o);
endinterface : rsbi_if
`default_nettype wire

// ---- rsbi_pkg.sv ----
// Constants and the zero-count function shared by both ends of the strobe and inversion link.
// Assumes a single 250 MHz core clock on each end.
package rsbi_pkg;
  localparam int BYTE_W = 8;
  localparam int DQ_W = 16;
  localparam int EDC_W = 4;
  localparam int ZERO_LIMIT = 4;
  localparam logic [3:0] HOLD_RESET = 4'hF;
  localparam logic [3:0] EDC_IDLE = 4'hF;
  localparam int MR2_STROBE_BIT = 9;
  localparam int MR1_READ_INVERSION_ENABLE_N_BIT = 8;
  localparam int MR4_ODD_INV_BIT = 11;
  localparam int MR4_WRITE_CHECKSUM_ENABLE_N_BIT = 10;
  localparam int MR4_READ_CHECKSUM_ENABLE_N_BIT = 9;
  localparam int MR4_HOLD_LSB = 0;
  localparam int MODE_REGISTER_TWELVE_PRBS_BIT = 2;
  localparam int MRS_DATA_W = 12;
  localparam logic [2:0] SEL_MR1 = 3'h1;
  localparam logic [2:0] SEL_MR2 = 3'h2;
  localparam logic [2:0] SEL_MR4 = 3'h4;
  localparam logic [2:0] SEL_MODE_REGISTER_TWELVE = 3'h6;
  localparam int MODE_SET_DELAY_NS = 40;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MODE_SET_CYCLES =
    (MODE_SET_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (MODE_SET_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [3:0] MODE_SET_CNT = 4'(MODE_SET_CYCLES);
  localparam int WB_AW = 4;
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_WDATA = 4'h4;
  localparam logic [3:0] ADDR_RDATA = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // Count zero bits of one byte
  function automatic logic [3:0] zeros(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < BYTE_W; i++) begin
      n = n + {3'h0, ~b[i]};
    end
    return n;
  endfunction : zeros
endpackage : rsbi_pkg

// ---- rsbi_properties.sv ----
// Concurrent checks on the pins between the two ends.
// Fed from the interface signals; one core clock domain.
`timescale 1ns/1ps
`default_nettype none
module rsbi_properties
  import rsbi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk,
  input wire logic mrs_valid,
  input wire logic [2:0] mrs_sel,
  input wire logic [11:0] mrs_data,
  input wire logic rd_cmd,
  input wire logic read_training_cmd_cmd,
  input wire logic [15:0] dq_dev,
  input wire logic dq_dev_oe,
  input wire logic [1:0] flag_dev,
  input wire logic [1:0] flag_dev_oe,
  input wire logic [1:0] flag_odt,
  input wire logic [3:0] edc_o,
  input wire logic [15:0] dq_ctl,
  input wire logic dq_ctl_oe,
  input wire logic flag_ctl_oe
);
  // Slack covers link edge sampling on top of the mode delay
  localparam int SETTLE = MODE_SET_CYCLES + 12;
  logic lc_q;
  logic strobe;
  logic odd;
  logic rd_seen;
  logic [3:0] hold;
  logic [6:0] quiet;
  logic [5:0] lo_age;
  logic take;
  logic settled;
  assign take = link_clk && !lc_q;
  assign settled = quiet >= 7'(SETTLE);

  always_ff @(posedge clk_i) begin
    lc_q <= link_clk;
    if (rst_i) begin
      strobe <= 1'b0;
      odd <= 1'b0;
      rd_seen <= 1'b1;
      hold <= HOLD_RESET;
      quiet <= 7'h00;
      lo_age <= 6'h00;
    end else begin
      lo_age <= edc_o[0] ? lo_age + {5'h00, lo_age != 6'h3F} : 6'h00;
      if (take && mrs_valid) begin
        quiet <= 7'h00;
        rd_seen <= 1'b0;
        if (mrs_sel == SEL_MR2) strobe <= mrs_data[MR2_STROBE_BIT];
        if (mrs_sel == SEL_MR4) hold <= mrs_data[3:0];
        if (mrs_sel == SEL_MR4) odd <= mrs_data[MR4_ODD_INV_BIT];
      end else begin
        quiet <= quiet + {6'h00, quiet != 7'h7F};
        if (take && (rd_cmd || read_training_cmd_cmd)) rd_seen <= 1'b1;
      end
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_burst_start;
    strobe && settled && $rose(dq_dev_oe);
  endsequence

  a_hold_outside: assert property (
    !strobe && settled |-> edc_o[0] == hold[0] && edc_o[2] == hold[2])
    else $error("hold pattern missing");
  a_strobe_idle: assert property (
    strobe && settled && !rd_seen |-> edc_o == EDC_IDLE)
    else $error("idle check pins not high");
  a_preamble_lead: assert property (
    s_burst_start |-> lo_age <= 6'h28)
    else $error("no strobe before first data");
  a_odd_pair: assert property (
    strobe && odd && settled && dq_dev_oe |->
      edc_o[1] != edc_o[0] && edc_o[3] != edc_o[2])
    else $error("odd pins not inverted");
  a_rd_zero_limit: assert property (
    dq_dev_oe && flag_dev_oe[0] |-> $countones(~dq_dev[7:0]) <= ZERO_LIMIT)
    else $error("too many low lines in byte zero");
  a_flag_low_inv: assert property (
    dq_dev_oe && flag_dev_oe[1] && !flag_dev[1] |->
      $countones(~dq_dev[15:8]) < ZERO_LIMIT)
    else $error("flag low on uninverted byte");
  a_odt_apart: assert property (
    (flag_dev_oe & flag_odt) == 2'b00)
    else $error("flag driven with termination on");
  a_wr_encoded: assert property (
    dq_ctl_oe && flag_ctl_oe |-> $countones(~dq_ctl[7:0]) <= ZERO_LIMIT
      && $countones(~dq_ctl[15:8]) <= ZERO_LIMIT)
    else $error("write byte not encoded");
  a_flag_with_data: assert property (
    flag_ctl_oe |-> dq_ctl_oe)
    else $error("write flag without data");
endmodule : rsbi_properties
`default_nettype wire
